/* hdl/tsa_params.svh */
`ifndef TSA_PARAMS_SVH
`define TSA_PARAMS_SVH

// ****************************************
// timing
// ****************************************
`define TSA_CLK_NS            20
`define TSA_LINK_MAX_KHZ      400
`define TSA_LINK_MIN_HALF_NS  (1000000 / (2 * `TSA_LINK_MAX_KHZ))
`define TSA_LINK_HALF_CYC     (`TSA_LINK_MIN_HALF_NS / `TSA_CLK_NS)
`define TSA_CONV_CYC_DEFAULT  32'h0000_2000

// ****************************************
// wishbone byte addresses
// ****************************************
`define TSA_ADR_TEMP          8'h00
`define TSA_ADR_CFG           8'h04
`define TSA_ADR_TOS           8'h08
`define TSA_ADR_HYSTERESIS_LIMIT          8'h0C
`define TSA_ADR_IRQ_STAT      8'h10
`define TSA_ADR_IRQ_MASK      8'h14
`define TSA_ADR_STATUS        8'h18

// ****************************************
// serial register pointers
// ****************************************
`define TSA_PTR_TEMP          2'h0
`define TSA_PTR_CFG           2'h1
`define TSA_PTR_HYSTERESIS_LIMIT          2'h2
`define TSA_PTR_TOS           2'h3

// ****************************************
// configuration fields
// ****************************************
`define TSA_CFG_SHDN          0
`define TSA_CFG_INT_MODE      1
`define TSA_CFG_FQ_LO         3
`define TSA_CFG_FQ_HI         4
`define TSA_CFG_RES_LO        5
`define TSA_CFG_RES_HI        6
`define TSA_CFG_RST           8'h00
`define TSA_CFG_MASK          8'h7B

// ****************************************
// reset values and constants
// ****************************************
`define TSA_TOS_RST           16'h4000
`define TSA_HYSTERESIS_LIMIT_RST          16'h3C00
`define TSA_I2C_ADDR_HI       4'h5
`define TSA_RES_LSB_MASK      16'h007F
`define TSA_FQ_N0             3'h1
`define TSA_FQ_N1             3'h2
`define TSA_FQ_N2             3'h4
`define TSA_FQ_N3             3'h6
`define TSA_IRQ_CONV          0
`define TSA_IRQ_ALARM         1

`endif

/* hdl/tsa_pkg.sv */
`default_nettype none
package tsa_pkg;
  typedef enum logic {
    watch_hot,
    watch_cold
  } watch_t;

  typedef enum logic [2:0] {
    ser_idle,
    ser_addr,
    ser_ack,
    ser_wr,
    ser_rd,
    ser_rack
  } ser_state_t;
endpackage : tsa_pkg
`default_nettype wire

/* hdl/thermal_cmp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface thermal_cmp_if;
  logic        conv_done;
  logic [15:0] temp;
  logic [15:0] overtemp_trip_limit;
  logic [15:0] hysteresis_limit;
  logic [1:0]  res;
  logic [1:0]  fq;
  logic        int_mode;
  logic        clear;
  logic        alarm;
  logic        alarm_set;

  modport core (output conv_done, temp, overtemp_trip_limit, hysteresis_limit, res, fq, int_mode, clear,
                input  alarm, alarm_set);
  modport eval (input  conv_done, temp, overtemp_trip_limit, hysteresis_limit, res, fq, int_mode, clear,
                output alarm, alarm_set);
endinterface : thermal_cmp_if
`default_nettype wire

/* hdl/sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

/* hdl/alarm_eval.sv */
`include "tsa_params.svh"
`timescale 1ns/10ps
`default_nettype none
module alarm_eval (
  input wire logic   clk_i,
  input wire logic   rst_i,
  thermal_cmp_if.eval c
);
  logic [15:0]          res_mask;
  logic signed [15:0]   t_m;
  logic signed [15:0]   tos_m;
  logic signed [15:0]   hysteresis_limit_m;
  logic                 hot;
  logic                 cold;
  logic                 watching_cold;
  logic                 hit;
  logic [2:0]           need;
  logic [2:0]           cnt;
  logic [2:0]           cnt_inc;
  logic                 fire;
  tsa_pkg::watch_t      phase;
  tsa_pkg::watch_t      next_phase;
  logic [2:0]           next_cnt;
  logic                 next_alarm;
  logic                 next_set;

  // only the bits the resolution provides take part
  assign res_mask = ~(`TSA_RES_LSB_MASK >> c.res);
  assign t_m      = c.temp & res_mask;
  assign tos_m    = c.overtemp_trip_limit & res_mask;
  assign hysteresis_limit_m   = c.hysteresis_limit & res_mask;
  assign hot      = t_m > tos_m;
  assign cold     = t_m < hysteresis_limit_m;

  assign need = (c.fq == 2'h0) ? `TSA_FQ_N0 :
                (c.fq == 2'h1) ? `TSA_FQ_N1 :
                (c.fq == 2'h2) ? `TSA_FQ_N2 : `TSA_FQ_N3;

  assign watching_cold = c.int_mode ? (phase == tsa_pkg::watch_cold) : c.alarm;
  assign hit     = watching_cold ? cold : hot;
  assign cnt_inc = cnt + 3'h1;
  assign fire    = cnt_inc >= need;

  always_comb begin
    next_cnt   = cnt;
    next_alarm = c.alarm;
    next_phase = phase;
    next_set   = 1'b0;
    // a trip in the same cycle as a clear stands: the read saw the older state
    if (c.int_mode && c.clear) begin
      next_alarm = 1'b0;
    end
    if (c.conv_done) begin
      if (!hit) begin
        next_cnt = 3'h0;
      end else if (c.int_mode) begin
        if (fire) begin
          // interrupt mode fires on both crossings, cycling the watch
          next_alarm = 1'b1;
          next_set   = 1'b1;
          next_cnt   = 3'h0;
          next_phase = (phase == tsa_pkg::watch_hot) ? tsa_pkg::watch_cold
                                                     : tsa_pkg::watch_hot;
        end else begin
          next_cnt = cnt_inc;
        end
      end else if (c.alarm) begin
        next_alarm = 1'b0;
        next_cnt   = 3'h0;
      end else if (fire) begin
        next_alarm = 1'b1;
        next_set   = 1'b1;
        next_cnt   = 3'h0;
      end else begin
        next_cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt         <= 3'h0;
      phase       <= tsa_pkg::watch_hot;
      c.alarm     <= 1'b0;
      c.alarm_set <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      phase       <= next_phase;
      c.alarm     <= next_alarm;
      c.alarm_set <= next_set;
    end
  end
endmodule : alarm_eval
`default_nettype wire

/* hdl/temp_sensor_alarm_core.sv */
// Function
// - after reset resolution is 9 bits and conversions run without any command
// - resolution selectable 9, 10, 11 or 12 bits
// - trip and hysteresis limits are separate 16-bit read/write registers
// - each new result is compared with the limits to drive the alarm
// - alarm runs in comparator mode or interrupt mode, chosen by software
// - alarm pin is open drain: it only pulls low or releases
// - three strap pins give the low three bits of the serial address
// - serial port works with link clocks up to 400 kHz
// - latest temperature result is readable at any time
// - fault queue field 00,01,10,11 means 1,2,4,6 consecutive faults, resets 00
// - comparator mode: trip after fault count hot, release below hysteresis
// - interrupt mode: cleared by shutdown or a read of temp, config, trip or hysteresis, then re-arms below hysteresis
// - result is left justified 16-bit two's complement, unused low bits zero
`include "tsa_params.svh"
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_alarm_core #(
  parameter logic [31:0] CONV_CYCLES = `TSA_CONV_CYC_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        irq_o,
  input  wire logic [15:0] adc_data_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic        addr_strap_bit0_i,
  input  wire logic        addr_strap_bit1_i,
  input  wire logic        addr_strap_bit2_i,
  input  wire logic        thermal_alarm_out_i,
  output var  logic        thermal_alarm_out_o,
  output var  logic        thermal_alarm_out_oe_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pins_raw;
  logic [5:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] strap_s;
  logic       alarm_pin_s;

  assign pins_raw = {thermal_alarm_out_i, addr_strap_bit2_i, addr_strap_bit1_i,
                     addr_strap_bit0_i, sda_i, scl_i};

  // at 50 MHz a 400 kHz link gives well over the needed samples per half period
  sync2 #(.W(6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pins_raw),
    .q_o   (pins_s)
  );

  assign scl_s       = pins_s[0];
  assign sda_s       = pins_s[1];
  assign strap_s     = pins_s[4:2];
  assign alarm_pin_s = pins_s[5];

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  cfg;
  logic [15:0] overtemp_trip_limit;
  logic [15:0] hysteresis_limit;
  logic [15:0] temp;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [15:0] res_mask;
  logic [1:0]  res;
  logic        shdn;

  assign res      = cfg[`TSA_CFG_RES_HI:`TSA_CFG_RES_LO];
  assign shdn     = cfg[`TSA_CFG_SHDN];
  assign res_mask = ~(`TSA_RES_LSB_MASK >> res);

  // ****************************************
  // conversion timebase
  // ****************************************
  logic [31:0] conv_cnt;
  logic        conv_done;
  logic        conv_end;

  assign conv_end = (conv_cnt == CONV_CYCLES - 32'h0000_0001);

  // counts from reset on, so the first result needs no bus access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_cnt  <= 32'h0000_0000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= !shdn && conv_end;
      if (shdn || conv_end) begin
        conv_cnt <= 32'h0000_0000;
      end else begin
        conv_cnt <= conv_cnt + 32'h0000_0001;
      end
    end
  end

  // result latched only at the end of a conversion; reads never disturb it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp <= 16'h0000;
    end else if (!shdn && conv_end) begin
      temp <= adc_data_i & res_mask;
    end
  end

  // ****************************************
  // alarm evaluation
  // ****************************************
  thermal_cmp_if cmp ();
  logic wb_reg_read;
  logic ser_rd_stb;

  assign cmp.conv_done = conv_done;
  assign cmp.temp      = temp;
  assign cmp.overtemp_trip_limit       = overtemp_trip_limit;
  assign cmp.hysteresis_limit      = hysteresis_limit;
  assign cmp.res       = res;
  assign cmp.fq        = cfg[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO];
  assign cmp.int_mode  = cfg[`TSA_CFG_INT_MODE];
  assign cmp.clear     = shdn || wb_reg_read || ser_rd_stb;

  alarm_eval u_eval (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .c     (cmp.eval)
  );

  // active low alarm: pull down while alarm is set, otherwise release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thermal_alarm_out_o    <= 1'b0;
      thermal_alarm_out_oe_o <= 1'b0;
    end else begin
      thermal_alarm_out_o    <= 1'b0;
      thermal_alarm_out_oe_o <= cmp.alarm;
    end
  end

  // ****************************************
  // serial slave engine
  // ****************************************
  tsa_pkg::ser_state_t st;
  logic       scl_p;
  logic       sda_p;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] sh;
  logic [3:0] nbit;
  logic       rw;
  logic [1:0] byte_n;
  logic [1:0] ptr;
  logic [7:0] hi_byte;
  logic       addr_hit;
  logic [15:0] ser_rdata;
  logic [7:0]  tx_byte;
  logic        ser_wr_stb;
  logic [15:0] ser_wdata;
  logic        byte_done;

  assign scl_rise  = scl_s && !scl_p;
  assign scl_fall  = !scl_s && scl_p;
  assign bus_start = scl_s && scl_p && sda_p && !sda_s;
  assign bus_stop  = scl_s && scl_p && !sda_p && sda_s;
  assign addr_hit  = (sh[7:1] == {`TSA_I2C_ADDR_HI, strap_s});
  assign byte_done = scl_fall && (nbit == 4'h8);
  assign ser_rdata = (ptr == `TSA_PTR_TEMP) ? temp :
                     (ptr == `TSA_PTR_CFG)  ? {cfg, cfg} :
                     (ptr == `TSA_PTR_HYSTERESIS_LIMIT) ? hysteresis_limit : overtemp_trip_limit;
  assign tx_byte   = byte_n[0] ? ser_rdata[7:0] : ser_rdata[15:8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= tsa_pkg::ser_idle;
      sh         <= 8'h00;
      nbit       <= 4'h0;
      rw         <= 1'b0;
      byte_n     <= 2'h0;
      ptr        <= `TSA_PTR_TEMP;
      hi_byte    <= 8'h00;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
      ser_rd_stb <= 1'b0;
      ser_wr_stb <= 1'b0;
      ser_wdata  <= 16'h0000;
    end else begin
      ser_rd_stb <= 1'b0;
      ser_wr_stb <= 1'b0;
      if (bus_start) begin
        st       <= tsa_pkg::ser_addr;
        nbit     <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        st       <= tsa_pkg::ser_idle;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (st)
          tsa_pkg::ser_idle: begin
            nbit <= 4'h0;
          end
          tsa_pkg::ser_addr: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda_s};
              nbit <= nbit + 4'h1;
            end else if (byte_done) begin
              nbit <= 4'h0;
              if (addr_hit) begin
                rw       <= sh[0];
                byte_n   <= 2'h0;
                sda_oe_o <= 1'b1;
                st       <= tsa_pkg::ser_ack;
              end else begin
                st <= tsa_pkg::ser_idle;
              end
            end
          end
          tsa_pkg::ser_ack: begin
            if (scl_fall) begin
              nbit <= 4'h0;
              if (rw) begin
                // reading any register counts as the clearing read
                ser_rd_stb <= (byte_n == 2'h0);
                sh         <= {tx_byte[6:0], 1'b1};
                sda_oe_o   <= !tx_byte[7];
                st         <= tsa_pkg::ser_rd;
              end else begin
                sda_oe_o <= 1'b0;
                st       <= tsa_pkg::ser_wr;
              end
            end
          end
          tsa_pkg::ser_wr: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda_s};
              nbit <= nbit + 4'h1;
            end else if (byte_done) begin
              if (byte_n == 2'h0) begin
                ptr <= sh[1:0];
              end else if (byte_n == 2'h1 && ptr == `TSA_PTR_CFG) begin
                ser_wdata  <= {8'h00, sh};
                ser_wr_stb <= 1'b1;
              end else if (byte_n == 2'h1) begin
                hi_byte <= sh;
              end else if (byte_n == 2'h2 && ptr[1]) begin
                ser_wdata  <= {hi_byte, sh};
                ser_wr_stb <= 1'b1;
              end
              if (byte_n != 2'h3) begin
                byte_n <= byte_n + 2'h1;
              end
              sda_oe_o <= 1'b1;
              st       <= tsa_pkg::ser_ack;
            end
          end
          tsa_pkg::ser_rd: begin
            if (scl_rise) begin
              nbit <= nbit + 4'h1;
            end else if (byte_done) begin
              sda_oe_o <= 1'b0;
              st       <= tsa_pkg::ser_rack;
            end else if (scl_fall) begin
              sda_oe_o <= !sh[7];
              sh       <= {sh[6:0], 1'b1};
            end
          end
          tsa_pkg::ser_rack: begin
            if (scl_rise) begin
              if (sda_s) begin
                st <= tsa_pkg::ser_idle;
              end else begin
                byte_n <= byte_n + 2'h1;
              end
            end else if (scl_fall) begin
              nbit     <= 4'h0;
              sh       <= {tx_byte[6:0], 1'b1};
              sda_oe_o <= !tx_byte[7];
              st       <= tsa_pkg::ser_rd;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  logic        wb_req;
  logic        wb_wr;
  logic        sel_cfg;
  logic        sel_tos;
  logic        sel_hysteresis_limit;
  logic        sel_temp;
  logic [15:0] lane_mask;
  logic [31:0] rd_mux;
  logic [15:0] wb_tos;
  logic [15:0] wb_hysteresis_limit;
  logic [7:0]  wb_cfg;

  assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr       = wb_req && wb_we_i;
  assign sel_temp    = wb_adr_i == `TSA_ADR_TEMP;
  assign sel_cfg     = wb_adr_i == `TSA_ADR_CFG;
  assign sel_tos     = wb_adr_i == `TSA_ADR_TOS;
  assign sel_hysteresis_limit    = wb_adr_i == `TSA_ADR_HYSTERESIS_LIMIT;
  assign wb_reg_read = wb_req && !wb_we_i && (sel_temp || sel_cfg || sel_tos || sel_hysteresis_limit);
  assign lane_mask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_tos      = (overtemp_trip_limit & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
  assign wb_hysteresis_limit     = (hysteresis_limit & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
  assign wb_cfg      = wb_sel_i[0] ? (wb_dat_i[7:0] & `TSA_CFG_MASK) : cfg;

  assign rd_mux = sel_temp                       ? {16'h0000, temp} :
                  sel_cfg                        ? {24'h00_0000, cfg} :
                  sel_tos                        ? {16'h0000, overtemp_trip_limit} :
                  sel_hysteresis_limit                       ? {16'h0000, hysteresis_limit} :
                  wb_adr_i == `TSA_ADR_IRQ_STAT  ? {30'h0000_0000, irq_stat} :
                  wb_adr_i == `TSA_ADR_IRQ_MASK  ? {30'h0000_0000, irq_mask} :
                  wb_adr_i == `TSA_ADR_STATUS    ? {27'h000_0000, strap_s,
                                                    alarm_pin_s, cmp.alarm} :
                  32'h0000_0000;

  // one wait state: ack and data both come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  // the bus port wins if both ports write the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg  <= `TSA_CFG_RST;
      overtemp_trip_limit  <= `TSA_TOS_RST;
      hysteresis_limit <= `TSA_HYSTERESIS_LIMIT_RST;
    end else begin
      if (wb_wr && sel_cfg) begin
        cfg <= wb_cfg;
      end else if (ser_wr_stb && ptr == `TSA_PTR_CFG) begin
        cfg <= ser_wdata[7:0] & `TSA_CFG_MASK;
      end
      if (wb_wr && sel_tos) begin
        overtemp_trip_limit <= wb_tos;
      end else if (ser_wr_stb && ptr == `TSA_PTR_TOS) begin
        overtemp_trip_limit <= ser_wdata;
      end
      if (wb_wr && sel_hysteresis_limit) begin
        hysteresis_limit <= wb_hysteresis_limit;
      end else if (ser_wr_stb && ptr == `TSA_PTR_HYSTERESIS_LIMIT) begin
        hysteresis_limit <= ser_wdata;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [1:0] irq_ev;
  logic [1:0] irq_w1c;
  logic [1:0] next_irq_stat;

  assign irq_ev        = {cmp.alarm_set, conv_done};
  assign irq_w1c       = (wb_wr && wb_adr_i == `TSA_ADR_IRQ_STAT && wb_sel_i[0])
                         ? wb_dat_i[1:0] : 2'h0;
  assign next_irq_stat = (irq_stat & ~irq_w1c) | irq_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wb_wr && wb_adr_i == `TSA_ADR_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[1:0];
      end
      irq_o <= |(next_irq_stat & irq_mask);
    end
  end

endmodule : temp_sensor_alarm_core
`default_nettype wire

/* tb/temp_sensor_alarm_core_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_alarm_core_checker #(
  parameter logic [31:0] CONV_CYCLES = 32'h0000_2000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        thermal_alarm_out_o,
  input wire logic        thermal_alarm_out_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_needs_request: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_temp_low_bits: assert property (wb_ack_o && $past(wb_adr_i) == 8'h00 && !$past(wb_we_i)
    |-> wb_dat_o[3:0] == 4'h0) else $error("temperature low bits set");
  a_alarm_drain: assert property (thermal_alarm_out_oe_o |-> !thermal_alarm_out_o)
    else $error("alarm pin driven high");
  a_sda_drain: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !thermal_alarm_out_oe_o
    && !sda_oe_o && !wb_ack_o) else $error("outputs active after reset");
endmodule : temp_sensor_alarm_core_checker
bind temp_sensor_alarm_core temp_sensor_alarm_core_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .thermal_alarm_out_o(thermal_alarm_out_o),
  .thermal_alarm_out_oe_o(thermal_alarm_out_oe_o));
`default_nettype wire

/* tb/serial_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_master_model (
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output var  logic scl_o,
  output wire logic sda_o
);
  logic pull_low = 1'b0;
  initial scl_o = 1'b1;
  // pull-up: the wire is high unless some party pulls it low
  assign sda_o = ~(pull_low | sda_oe_i);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic bit_out(input logic b);
    tick(2);
    pull_low <= ~b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask : bit_out
  // start, one address byte, ack slot, stop; clock stands high outside
  task automatic probe(input logic [7:0] adr, output logic acked);
    pull_low <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    for (int i = 7; i >= 0; i--) bit_out(adr[i]);
    tick(2);
    pull_low <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    acked = ~sda_o;
    tick(2);
    scl_o <= 1'b0;
    tick(2);
    pull_low <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    pull_low <= 1'b0;
    tick(8);
  endtask : probe
endmodule : serial_master_model
`default_nettype wire

/* tb/temp_sensor_alarm_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", n, e, g); failures++; end end
module temp_sensor_alarm_core_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        wen = 1'b0;
  logic        a;
  logic [7:0]  adr = 8'h00;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] adc = 16'h0000;
  logic [15:0] q;
  logic [2:0]  straps = 3'b101;
  wire logic   scl, sda, irq, ack, sda_oe, al_oe;
  wire logic [31:0] rdat;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          fq_n[4] = '{1, 2, 4, 6};
  always #10 clk_i = ~clk_i;
  temp_sensor_alarm_core #(.CONV_CYCLES(32'h0000_0010)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i({16'h0000, wdat}), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .adc_data_i(adc), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .addr_strap_bit0_i(straps[0]), .addr_strap_bit1_i(straps[1]),
    .addr_strap_bit2_i(straps[2]), .thermal_alarm_out_i(~al_oe),
    .thermal_alarm_out_o(), .thermal_alarm_out_oe_o(al_oe));
  serial_master_model host (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic wb(input logic w, input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= ad;
    wdat <= d;
    // only ack or the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // waits for k fresh conversions, using the done flag as the only sign
  task automatic conv(input int k);
    int n;
    repeat (k) begin
      wb(1'b1, 8'h10, 16'h0003);
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (irq !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      repeat (3) @(posedge clk_i);
    end
  endtask : conv
  task automatic t_reset_regs;
    wb(1'b0, 8'h04, 16'h0000);
    `CHK("cfg", 16'h0000, q)
    wb(1'b0, 8'h08, 16'h0000);
    `CHK("trip", 16'h4000, q)
    wb(1'b0, 8'h0C, 16'h0000);
    `CHK("hyst", 16'h3C00, q)
    wb(1'b1, 8'h08, 16'hA5C0);
    wb(1'b1, 8'h0C, 16'h1230);
    wb(1'b0, 8'h08, 16'h0000);
    `CHK("trip rw", 16'hA5C0, q)
    wb(1'b0, 8'h0C, 16'h0000);
    `CHK("hyst rw", 16'h1230, q)
    wb(1'b1, 8'h08, 16'h4000);
    wb(1'b1, 8'h0C, 16'h3C00);
    wb(1'b1, 8'h1C, 16'hFFFF);
    wb(1'b0, 8'h1C, 16'h0000);
    `CHK("unmapped", 16'h0000, q)
    wb(1'b1, 8'h14, 16'h0000);
    wb(1'b1, 8'h10, 16'h0003);
    repeat (40) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq)
    wb(1'b0, 8'h10, 16'h0000);
    `CHK("free running", 1'b1, q[0])
    wb(1'b1, 8'h14, 16'h0001);
  endtask : t_reset_regs
  task automatic t_resolution;
    adc <= 16'h3AFF;
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, 8'h04, 16'(r << 5));
      conv(2);
      wb(1'b0, 8'h00, 16'h0000);
      `CHK("temp", 16'h3AFF & ~(16'h007F >> r), q)
    end
    wb(1'b1, 8'h04, 16'h0000);
  endtask : t_resolution
  task automatic t_comparator;
    adc <= 16'hC000;
    conv(1);
    `CHK("signed compare", 1'b0, al_oe)
    adc <= 16'h4040;
    conv(2);
    `CHK("9 bit compare", 1'b0, al_oe)
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, 8'h04, 16'(f << 3));
      adc <= 16'h4100;
      for (int i = 1; i <= fq_n[f]; i++) begin
        conv(1);
        `CHK("trip count", (i == fq_n[f]), al_oe)
      end
      wb(1'b0, 8'h18, 16'h0000);
      `CHK("status", 5'b10101, q[4:0])
      adc <= 16'h3000;
      conv(1);
      `CHK("release", 1'b0, al_oe)
    end
  endtask : t_comparator
  task automatic t_interrupt;
    wb(1'b1, 8'h04, 16'h0002);
    adc <= 16'h4100;
    conv(2);
    `CHK("int trip", 1'b1, al_oe)
    wb(1'b0, 8'h08, 16'h0000);
    repeat (2) @(posedge clk_i);
    `CHK("read clears", 1'b0, al_oe)
    conv(1);
    `CHK("no re-trip hot", 1'b0, al_oe)
    adc <= 16'h3000;
    conv(1);
    `CHK("re-arm cold", 1'b1, al_oe)
    wb(1'b1, 8'h04, 16'h0003);
    repeat (2) @(posedge clk_i);
    `CHK("shutdown clears", 1'b0, al_oe)
    wb(1'b1, 8'h04, 16'h0000);
  endtask : t_interrupt
  task automatic t_serial;
    host.probe(8'h5A, a);
    `CHK("own address", 1'b1, a)
    host.probe(8'h58, a);
    `CHK("other address", 1'b0, a)
  endtask : t_serial
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_regs();
    t_resolution();
    t_comparator();
    t_interrupt();
    t_serial();
    report_and_stop();
  end
endmodule : temp_sensor_alarm_core_tb
`default_nettype wire
